//--- src/gpio_defs.svh
`ifndef GPIO_DEFS_SVH
`define GPIO_DEFS_SVH

// ----------------------------------------
// Register indices, byte address = 4 * index
// ----------------------------------------
`define GPIO_IDX_PORT0_DATA 10'h080
`define GPIO_IDX_P1_DATA 10'h090
`define GPIO_IDX_P2_DATA 10'h0a0
`define GPIO_IDX_P5_DATA 10'h0d8
`define GPIO_IDX_PORT0_DIR 10'h09a
`define GPIO_IDX_PORT0_PULL 10'h09b
`define GPIO_IDX_P1_DIR 10'h091
`define GPIO_IDX_P1_PULL 10'h092
`define GPIO_IDX_P2_DIR 10'h0a1
`define GPIO_IDX_P2_PULL 10'h0a2
`define GPIO_IDX_P5_DIR 10'h0d9
`define GPIO_IDX_P5_PULL 10'h0da

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define GPIO_IDX_LSB 2
`define GPIO_IDX_MSB 11
`define GPIO_MASK_FULL 8'hff
`define GPIO_MASK_P5 8'h03
`define GPIO_RST_DATA 8'h00
`define GPIO_RST_DIR 8'h00
`define GPIO_RST_PULL 8'h00
`define GPIO_RST_WORD 32'h0000_0000

`endif

//--- src/gpio_pkg.sv
package gpio_pkg;
    typedef logic [7:0] port_byte_t;
    typedef logic [9:0] reg_index_t;
    typedef enum logic {
        APB_IDLE,
        APB_ANSWER
    } apb_phase_t;
endpackage

//--- src/gpio_port_bank.sv
// Function
// - Direction bit 0 makes the pin an input, 1 a push-pull output.
// - Pull-up bit acts only while direction is 0; 1 turns pull-up on.
// - After reset every direction and pull-up bit is 0.
// - Reading a data register returns the actual pin levels.
// - Pull-up input reads low only when driven low externally.
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "gpio_defs.svh"

module gpio_port_bank
    import gpio_pkg::*;
(
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port 0 pins
    input wire logic [7:0] p0_in,
    output logic [7:0] p0_out,
    output logic [7:0] p0_oe_n,
    output logic [7:0] p0_pullup,
    // Port 1 pins
    input wire logic [7:0] p1_in,
    output logic [7:0] p1_out,
    output logic [7:0] p1_oe_n,
    output logic [7:0] p1_pullup,
    // Port 2 pins
    input wire logic [7:0] p2_in,
    output logic [7:0] p2_out,
    output logic [7:0] p2_oe_n,
    output logic [7:0] p2_pullup,
    // Port 5 pins
    input wire logic [1:0] p5_in,
    output logic [1:0] p5_out,
    output logic [1:0] p5_oe_n,
    output logic [1:0] p5_pullup
);

    // ----------------------------------------
    // Per-port tables
    // ----------------------------------------
    localparam int NPORT = 4;
    localparam reg_index_t DATA_IDX [NPORT] = '{
        `GPIO_IDX_PORT0_DATA, `GPIO_IDX_P1_DATA, `GPIO_IDX_P2_DATA, `GPIO_IDX_P5_DATA
    };
    localparam reg_index_t DIR_IDX [NPORT] = '{
        `GPIO_IDX_PORT0_DIR, `GPIO_IDX_P1_DIR, `GPIO_IDX_P2_DIR, `GPIO_IDX_P5_DIR
    };
    localparam reg_index_t PULL_IDX [NPORT] = '{
        `GPIO_IDX_PORT0_PULL, `GPIO_IDX_P1_PULL, `GPIO_IDX_P2_PULL, `GPIO_IDX_P5_PULL
    };
    // Port 5 has two pins; unimplemented bits hold zero
    localparam port_byte_t MASK [NPORT] = '{
        `GPIO_MASK_FULL, `GPIO_MASK_FULL, `GPIO_MASK_FULL, `GPIO_MASK_P5
    };

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    port_byte_t pin_raw [NPORT];
    port_byte_t pin_meta [NPORT];
    port_byte_t pin_level [NPORT];
    port_byte_t data_q [NPORT];
    port_byte_t dir_q [NPORT];
    port_byte_t pull_q [NPORT];
    port_byte_t drive_out [NPORT];
    port_byte_t drive_oe_n [NPORT];
    port_byte_t drive_pull [NPORT];
    logic [NPORT-1:0] hit_data;
    logic [NPORT-1:0] hit_dir;
    logic [NPORT-1:0] hit_pull;
    reg_index_t bus_index;
    logic bus_mapped;
    logic access_go;
    logic write_go;
    port_byte_t next_rdata;
    apb_phase_t phase;

    assign pin_raw[0] = p0_in;
    assign pin_raw[1] = p1_in;
    assign pin_raw[2] = p2_in;
    assign pin_raw[3] = {6'h00, p5_in};

    // ----------------------------------------
    // Bus decode
    // ----------------------------------------
    assign bus_index = paddr[`GPIO_IDX_MSB:`GPIO_IDX_LSB];
    assign bus_mapped = |{hit_data, hit_dir, hit_pull};
    // One wait state: answer flop set on the first access cycle
    assign access_go = ce && psel && penable && (phase == APB_IDLE);
    assign write_go = ce && psel && penable && pwrite && (phase == APB_ANSWER);

    genvar gi;
    generate
        for (gi = 0; gi < NPORT; gi++) begin : g_port
            assign hit_data[gi] = (bus_index == DATA_IDX[gi]);
            assign hit_dir[gi] = (bus_index == DIR_IDX[gi]);
            assign hit_pull[gi] = (bus_index == PULL_IDX[gi]);

            // Two-stage synchroniser; pins are asynchronous to pclk
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    pin_meta[gi] <= `GPIO_RST_DATA;
                    pin_level[gi] <= `GPIO_RST_DATA;
                end else if (ce) begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_level[gi] <= pin_meta[gi] & MASK[gi];
                end
            end

            // Configuration and output latch
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir_q[gi] <= `GPIO_RST_DIR;
                    pull_q[gi] <= `GPIO_RST_PULL;
                    data_q[gi] <= `GPIO_RST_DATA;
                end else if (write_go) begin
                    if (hit_dir[gi]) begin
                        dir_q[gi] <= pwdata[7:0] & MASK[gi];
                    end
                    if (hit_pull[gi]) begin
                        pull_q[gi] <= pwdata[7:0] & MASK[gi];
                    end
                    if (hit_data[gi]) begin
                        data_q[gi] <= pwdata[7:0] & MASK[gi];
                    end
                end
            end

            // Pin drive: enable low while driving
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    drive_out[gi] <= `GPIO_RST_DATA;
                    drive_oe_n[gi] <= `GPIO_MASK_FULL;
                    drive_pull[gi] <= `GPIO_RST_PULL;
                end else if (ce) begin
                    drive_out[gi] <= data_q[gi] & dir_q[gi];
                    drive_oe_n[gi] <= ~dir_q[gi];
                    // Pull-up follows its pull bit in input mode only, so an open pulled-up pin reads high
                    drive_pull[gi] <= pull_q[gi] & ~dir_q[gi];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    always_comb begin
        next_rdata = `GPIO_RST_DATA;
        for (int i = 0; i < NPORT; i++) begin
            // Data reads give the live pin, not the latch
            if (hit_data[i]) begin
                next_rdata = next_rdata | pin_level[i];
            end
            if (hit_dir[i]) begin
                next_rdata = next_rdata | dir_q[i];
            end
            if (hit_pull[i]) begin
                next_rdata = next_rdata | pull_q[i];
            end
        end
    end

    // ----------------------------------------
    // APB answer
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= APB_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `GPIO_RST_WORD;
        end else if (ce) begin
            case (phase)
                APB_IDLE: begin
                    if (access_go) begin
                        phase <= APB_ANSWER;
                        pready <= 1'b1;
                        pslverr <= ~bus_mapped;
                        prdata <= (!pwrite && bus_mapped) ? {24'h00_0000, next_rdata}
                                                          : `GPIO_RST_WORD;
                    end
                end
                APB_ANSWER: begin
                    phase <= APB_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    prdata <= `GPIO_RST_WORD;
                end
                default: begin
                    phase <= APB_IDLE;
                    pready <= 1'b0;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Pin outputs
    // ----------------------------------------
    assign p0_out = drive_out[0];
    assign p0_oe_n = drive_oe_n[0];
    assign p0_pullup = drive_pull[0];
    assign p1_out = drive_out[1];
    assign p1_oe_n = drive_oe_n[1];
    assign p1_pullup = drive_pull[1];
    assign p2_out = drive_out[2];
    assign p2_oe_n = drive_oe_n[2];
    assign p2_pullup = drive_pull[2];
    assign p5_out = drive_out[3][1:0];
    assign p5_oe_n = drive_oe_n[3][1:0];
    assign p5_pullup = drive_pull[3][1:0];

endmodule // gpio_port_bank

//--- verif/gpio_port_bank_chk.sv
`timescale 1ns/1ps
module gpio_port_bank_chk (
    // APB side
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    // Port 0 pins
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe_n,
    input wire logic [7:0] p0_pullup
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence wdone(logic [11:0] a);
        psel && penable && pready && pwrite && paddr == a && !pslverr;
    endsequence
    sequence take;
        $rose(penable) && psel && ce ##1 ce;
    endsequence
    a_answer_next: assert property (take |-> pready) else $error("late answer");
    a_ready_pulse: assert property (pready |=> !pready) else $error("long ready");
    a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
    a_ce_freeze: assert property (!ce |=> $stable(p0_oe_n) && $stable(p0_out) && $stable(pready))
        else $error("state moved while frozen");
    a_reset_idle: assert property ($rose(presetn) |-> &p0_oe_n && p0_pullup == 8'h00)
        else $error("pins not idle");
    a_dir_to_oe: assert property (wdone(12'h268) |-> ##2
        p0_oe_n == ~$past(pwdata[7:0], 2)) else $error("oe_n wrong");
    a_data_to_out: assert property (wdone(12'h200) |-> ##2
        (p0_out & ~p0_oe_n) == ($past(pwdata[7:0], 2) & ~p0_oe_n)) else $error("out wrong");
    a_pull_write: assert property (wdone(12'h26c) |-> ##2
        p0_pullup == ($past(pwdata[7:0], 2) & p0_oe_n)) else $error("pullup wrong");
    a_pull_input: assert property ((p0_pullup & ~p0_oe_n) == 8'h00)
        else $error("pullup on output");
endmodule // gpio_port_bank_chk
bind gpio_port_bank gpio_port_bank_chk chk_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .pslverr, .p0_out, .p0_oe_n, .p0_pullup);

//--- verif/gpio_pin_model.sv
`timescale 1ns/1ps
module gpio_pin_model (
    // Block side
    input wire logic clk,
    input wire logic [25:0] out,
    input wire logic [25:0] oe_n,
    input wire logic [25:0] pull_on,
    // Outside drivers and level
    input wire logic [25:0] ext_en,
    input wire logic [25:0] ext_val,
    output logic [25:0] lvl
);
    logic [25:0] flt = 26'h000_0000;
    // Floating pin wanders so a stale value cannot pass
    always @(posedge clk) flt <= ~flt;
    assign lvl = (~oe_n & out) | (oe_n & ext_en & ext_val)
        | (oe_n & ~ext_en & pull_on) | (oe_n & ~ext_en & ~pull_on & flt);
endmodule // gpio_pin_model

//--- verif/gpio_port_bank_test.sv
`timescale 1ns/1ps
module gpio_port_bank_test
    import gpio_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, ce = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, ext_en = 32'h0000_0000, ext_val = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready, pslverr;
    logic [7:0] p0_in, p0_out, p0_oe_n, p0_pullup, p1_in, p1_out, p1_oe_n, p1_pullup;
    logic [7:0] p2_in, p2_out, p2_oe_n, p2_pullup;
    logic [1:0] p5_in, p5_out, p5_oe_n, p5_pullup;
    logic [25:0] lvl;
    logic [33:0] exp_q[$];
    logic [33:0] e;
    int failures = 0, checks_done = 0, cyc = 0, seed = 32'h4e0e_a491;
    logic [11:0] dat_a[4] = '{12'h200, 12'h240, 12'h280, 12'h360};
    logic [11:0] dir_a[4] = '{12'h268, 12'h244, 12'h284, 12'h364};
    logic [11:0] pul_a[4] = '{12'h26c, 12'h248, 12'h288, 12'h368};
    port_byte_t dm, dv, pm, en, mk;
    always #2.5 pclk = ~pclk;
    assign {p5_in, p2_in, p1_in, p0_in} = lvl;
    gpio_port_bank dut_u (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .p0_in, .p0_out, .p0_oe_n, .p0_pullup, .p1_in, .p1_out,
        .p1_oe_n, .p1_pullup, .p2_in, .p2_out, .p2_oe_n, .p2_pullup, .p5_in, .p5_out,
        .p5_oe_n, .p5_pullup);
    gpio_pin_model pins_u (.clk(pclk), .out({p5_out, p2_out, p1_out, p0_out}),
        .oe_n({p5_oe_n, p2_oe_n, p1_oe_n, p0_oe_n}),
        .pull_on({p5_pullup, p2_pullup, p1_pullup, p0_pullup}),
        .ext_en(ext_en[25:0]), .ext_val(ext_val[25:0]), .lvl(lvl));
    task automatic close_out;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Request stays up after the answer so calls may run back to back
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            input logic [32:0] x);
        exp_q.push_back({~w, x});
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
    endtask
    task automatic idle(input int n);
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge pclk);
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures = failures + 1;
            close_out;
        end
        if (psel && penable && pready === 1'b1) begin
            e = exp_q.pop_front();
            checks_done = checks_done + 1;
            if ({pslverr, prdata & {32{e[33]}}} !== e[32:0]) begin
                failures = failures + 1;
                $display("BAD t=%0t got=%h exp=%h", $time, {pslverr, prdata}, e[32:0]);
            end
        end
    end
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        ce <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            mk = (k == 3) ? 8'h03 : 8'hff;
            dv = 8'($random(seed));
            ext_en[k*8 +: 8] <= 8'hff;
            ext_val[k*8 +: 8] <= dv;
            xfer(1'b0, dir_a[k], 32'h0, 33'h0);
            xfer(1'b0, pul_a[k], 32'h0, 33'h0);
            xfer(1'b0, dat_a[k], 32'h0, {25'h0, dv & mk});
            dm = 8'($random(seed));
            dv = 8'($random(seed));
            pm = 8'($random(seed));
            en = ~dm & (~pm | 8'($random(seed)));
            // Output pins left unloaded, floating inputs never read
            ext_en[k*8 +: 8] <= en;
            ext_val[k*8 +: 8] <= 8'h00;
            xfer(1'b1, dir_a[k], {24'h0, dm}, 33'h0);
            xfer(1'b1, pul_a[k], {24'h0, pm}, 33'h0);
            xfer(1'b1, dat_a[k], {24'h0, dv}, 33'h0);
            xfer(1'b1, 12'h004, {24'h0, dv}, {1'b1, 32'h0});
            xfer(1'b0, 12'h004, 32'h0, {1'b1, 32'h0});
            xfer(1'b0, dir_a[k], 32'h0, {25'h0, dm & mk});
            xfer(1'b0, pul_a[k], 32'h0, {25'h0, pm & mk});
            idle(4);
            xfer(1'b0, dat_a[k], 32'h0, {25'h0, ((dm & dv) | (~dm & ~en)) & mk});
            idle(1);
        end
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        // Enable low for a while: pins and bus answer must hold still
        ce <= 1'b0;
        idle(3);
        ce <= 1'b1;
        @(posedge pclk);
        for (int k = 0; k < 4; k++) begin
            xfer(1'b0, dir_a[k], 32'h0, 33'h0);
            xfer(1'b0, pul_a[k], 32'h0, 33'h0);
        end
        idle(2);
        close_out;
    end
endmodule // gpio_port_bank_test
